/* static_mem_wait_slow_page.sv */
// Functional notes
// R1 - Wait mode 10 frozen, 11 ready, 00 ignores the wait input.
// R2 - Wait applies to the controlling strobe chosen by read and write modes.
// R3 - Software must program hold cycles when waiting; no wait with page or slow mode.
// R4 - Wait input is sampled only during the controlling strobe pulse phase.
// R5 - Frozen mode: asserted wait freezes counters and holds every control output.
// R6 - Frozen mode: on release, resume from frozen counter state and finish.
// R7 - Ready mode: test wait in last pulse cycle; stall, then run hold.
// R8 - Ready mode: wait released before pulse end or raised after never lengthens.
// R9 - Two-cycle wait synchronizer; software programs pulse of latency plus three.
// R10 - Slow clock indication overrides programmed timings on all chip selects.
// R11 - Slow read 1/1/0/2/2, slow write 1/1/0/3/3 cycles.
// R12 - Transfer in progress when slow mode ends finishes with slow timings.
// R13 - Entering or leaving slow mode inserts a reload cycle after current transfer.
// R14 - Page reads only with page mode enabled; page size 4, 8, 16, 32 bytes.
// R15 - Pages size-aligned; address bits 25 down to above size identify page.
// R16 - In-page offset ignores bit 0 for 16-bit, bits 1:0 for 32-bit.
// R17 - Page mode: read strobe and chip select low with identical timing.
// R18 - First page access uses chip-select pulse, later accesses strobe pulse.
// R19 - Byte access type stays in effect in page mode; software sets zero.
// R20 - Software must not combine wait input with page mode.
// R21 - Same chip select and page as previous access is in-page, short time.
// R22 - Different page, chip select, or intervening access starts long page access.
// R23 - Wait synchronizer resets deasserted so nothing stalls after reset.
`default_nettype none
module static_mem_wait_slow_page (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// Access request from the internal master
	input wire static_mem_pkg::acc_req_s REQ,
	input wire static_mem_pkg::cs_cfg_s CFG,
	output logic REQ_READY,
	output logic ACC_DONE,
	// Power management
	input wire logic SLOW_CLK_MODE,
	// External memory
	input wire logic EXT_WAIT_N,
	output var static_mem_pkg::mem_ctl_s MEM_CTL,
	output logic [static_mem_pkg::ADDR_BITS-1:0] MEM_ADDR,
	output logic BYTE_SEL_MODE,
	output logic PAGE_HIT
);
	import static_mem_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Page decode

	function automatic logic [ADDR_BITS-1:0] page_mask(input logic [1:0] ps);
		logic [ADDR_BITS-1:0] m;
		m = '1;
		unique case (ps)
			PAGE_4: m[1:0] = 2'h0;
			PAGE_8: m[2:0] = 3'h0;
			PAGE_16: m[3:0] = 4'h0;
			PAGE_32: m[4:0] = 5'h00;
		endcase
		page_mask = m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		acc_state_e st;
		logic write;
		logic [CS_BITS-1:0] cs;
		logic [ADDR_BITS-1:0] addr;
		logic [CNT_BITS-1:0] cnt;
		logic [CNT_BITS-1:0] stb_on;
		logic [CNT_BITS-1:0] stb_off;
		logic [CNT_BITS-1:0] cs_on;
		logic [CNT_BITS-1:0] cs_off;
		logic [CNT_BITS-1:0] total;
		logic [1:0] wmode;
		logic ctl_by_strobe;
		logic slow_xfer;
		logic slow_seen;
		logic page_open;
		logic [CS_BITS-1:0] page_cs;
		logic [ADDR_BITS-1:0] page_addr;
		logic req_ready;
		logic done;
		logic hit;
		logic byte_mode;
		mem_ctl_s ctl;
	} ctrl_s;

	////////////////////////////////////////////////////////////////////////////////
	// Waveform decode

	// True while on <= n < off
	function automatic logic in_span(input logic [CNT_BITS-1:0] n,
		input logic [CNT_BITS-1:0] on, input logic [CNT_BITS-1:0] off);
		in_span = (n >= on) && (n < off);
	endfunction

	// Control levels for cycle index n of a running access; index 0 is the
	// second cycle after the take, so a zero setup still leaves the line high for one cycle
	function automatic mem_ctl_s wave_at(input ctrl_s s, input logic [CNT_BITS-1:0] n);
		mem_ctl_s c;
		c.chip_sel_n = !in_span(n, s.cs_on, s.cs_off);
		c.read_strobe_n = s.write || !in_span(n, s.stb_on, s.stb_off);
		c.write_strobe_n = !s.write || !in_span(n, s.stb_on, s.stb_off);
		wave_at = c;
	endfunction

	ctrl_s state;
	ctrl_s next_state;
	logic wait_n_sync;

	wait_sync u_wait_sync (
		.clk(CORE_CLK),
		.rst_n(RSTN),
		.wait_n_in(EXT_WAIT_N),
		.wait_n_sync(wait_n_sync)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic [CNT_BITS-1:0] cnt_inc;
		logic [CNT_BITS-1:0] cnt_dec;
		logic in_pulse;
		logic last_pulse;
		logic wait_on;
		logic freeze;
		logic page_req;
		logic same_page;
		logic [ADDR_BITS-1:0] pmask;
		logic [ADDR_BITS-1:0] omask;
		cnt_inc = state.cnt + 10'h001;
		cnt_dec = state.cnt - 10'h001;
		in_pulse = 1'b0;
		last_pulse = 1'b0;
		wait_on = 1'b0;
		freeze = 1'b0;
		page_req = 1'b0;
		same_page = 1'b0;
		pmask = page_mask(CFG.page_size_sel);
		omask = '1;
		next_state = state;
		next_state.done = 1'b0;
		unique case (state.st)
			ST_IDLE: begin
				next_state.req_ready = 1'b1;
				next_state.ctl = '{chip_sel_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1};
				if (SLOW_CLK_MODE != state.slow_seen) begin
					next_state.st = ST_RELOAD; // R13
					next_state.req_ready = 1'b0;
					next_state.slow_seen = SLOW_CLK_MODE;
				end else if (REQ.valid && state.req_ready) begin
					next_state.req_ready = 1'b0;
					next_state.write = REQ.write;
					next_state.cs = REQ.cs;
					next_state.addr = REQ.addr;
					next_state.cnt = CNT_RESET;
					next_state.byte_mode = CFG.byte_access_type; // R19
					next_state.slow_xfer = SLOW_CLK_MODE; // R12
					page_req = CFG.page_mode_en && !REQ.write && !SLOW_CLK_MODE; // R14
					if (CFG.bus_width == DBW_16) begin
						omask[0] = 1'b0; // R16
					end else if (CFG.bus_width == DBW_32) begin
						omask[1:0] = 2'h0; // R16
					end
					same_page = state.page_open && (state.page_cs == REQ.cs)
						&& ((state.page_addr & pmask) == (REQ.addr & pmask)); // R15 R21
					next_state.hit = page_req && same_page;
					if (SLOW_CLK_MODE) begin
						next_state.wmode = WAIT_OFF; // R10
						next_state.ctl_by_strobe = 1'b1;
						next_state.stb_on = SLOW_STB_SETUP; // R11
						next_state.stb_off = SLOW_STB_SETUP + SLOW_STB_PULSE;
						next_state.cs_on = SLOW_CS_SETUP;
						next_state.cs_off = REQ.write ? SLOW_WR_CS_PULSE : SLOW_RD_CS_PULSE;
						next_state.total = REQ.write ? SLOW_WR_CYCLE : SLOW_RD_CYCLE;
						next_state.page_open = 1'b0;
						next_state.st = ST_RUN;
					end else if (page_req) begin
						next_state.wmode = WAIT_OFF;
						next_state.total = same_page ? pulse_len(CFG.rd_strobe_pulse)
							: pulse_len(CFG.cs_rd_pulse); // R18 R21 R22
						next_state.addr = same_page ? (REQ.addr & omask) : REQ.addr;
						next_state.page_open = 1'b1;
						next_state.page_cs = REQ.cs;
						next_state.page_addr = REQ.addr;
						next_state.ctl = '{chip_sel_n: 1'b0, read_strobe_n: 1'b0,
							write_strobe_n: 1'b1}; // R17
						next_state.st = ST_PAGE;
					end else begin
						next_state.page_open = 1'b0; // R22
						next_state.wmode = CFG.wait_mode_sel; // R1
						if (REQ.write) begin
							next_state.ctl_by_strobe = CFG.write_mode; // R2
							next_state.stb_on = setup_len(CFG.wr_strobe_setup);
							next_state.stb_off = setup_len(CFG.wr_strobe_setup)
								+ pulse_len(CFG.wr_strobe_pulse);
							next_state.cs_on = setup_len(CFG.cs_wr_setup);
							next_state.cs_off = setup_len(CFG.cs_wr_setup)
								+ pulse_len(CFG.cs_wr_pulse);
							next_state.total = cycle_len(CFG.wr_cycle_len);
						end else begin
							next_state.ctl_by_strobe = CFG.read_mode; // R2
							next_state.stb_on = setup_len(CFG.rd_strobe_setup);
							next_state.stb_off = setup_len(CFG.rd_strobe_setup)
								+ pulse_len(CFG.rd_strobe_pulse);
							next_state.cs_on = setup_len(CFG.cs_rd_setup);
							next_state.cs_off = setup_len(CFG.cs_rd_setup)
								+ pulse_len(CFG.cs_rd_pulse);
							next_state.total = cycle_len(CFG.rd_cycle_len);
						end
						next_state.st = ST_RUN;
					end
				end else if (REQ.valid == 1'b0 && state.page_open) begin
					next_state.page_open = state.page_open;
				end
			end
			ST_RUN: begin
				// The counter runs one ahead of the waveform index shown on the pins
				if (state.ctl_by_strobe) begin
					in_pulse = in_span(cnt_dec, state.stb_on, state.stb_off); // R4
					last_pulse = (state.cnt == state.stb_off);
				end else begin
					in_pulse = in_span(cnt_dec, state.cs_on, state.cs_off); // R4
					last_pulse = (state.cnt == state.cs_off);
				end
				wait_on = !wait_n_sync && (state.wmode != WAIT_OFF) && in_pulse; // R1 R4
				if (state.wmode == WAIT_FROZEN) begin
					freeze = wait_on; // R5 R6
				end else if (state.wmode == WAIT_READY) begin
					freeze = wait_on && last_pulse; // R7 R8
				end
				if (freeze) begin
					next_state.cnt = state.cnt; // R5
					next_state.ctl = state.ctl;
					if (state.wmode == WAIT_READY) begin
						next_state.st = ST_READY_HOLD; // R7
					end
				end else begin
					next_state.cnt = cnt_inc; // R6
					next_state.ctl = wave_at(state, state.cnt); // R2
					// Last index shown is total-1; the access ends after it
					if (state.cnt >= state.total) begin
						next_state.st = ST_IDLE;
						next_state.done = 1'b1;
						next_state.ctl = '{chip_sel_n: 1'b1, read_strobe_n: 1'b1,
							write_strobe_n: 1'b1};
					end
				end
			end
			ST_READY_HOLD: begin
				if (wait_n_sync) begin
					next_state.cnt = cnt_inc; // R7
					next_state.st = ST_RUN;
					// Hold phase resumes from the index after the stalled pulse cycle
					next_state.ctl = wave_at(state, state.cnt); // R7
				end
			end
			ST_PAGE: begin
				next_state.cnt = cnt_inc;
				if (cnt_inc >= state.total) begin
					next_state.done = 1'b1;
					next_state.st = ST_IDLE; // R17
					next_state.ctl = '{chip_sel_n: 1'b1, read_strobe_n: 1'b1,
						write_strobe_n: 1'b1};
				end
			end
			ST_RELOAD: begin
				next_state.st = ST_IDLE; // R13
				next_state.page_open = 1'b0;
			end
			default: begin
				next_state.st = ST_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CORE_CLK) begin
		if (!RSTN) begin
			state <= '0;
			state.st <= ST_IDLE;
			state.ctl <= '{chip_sel_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1};
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign REQ_READY = state.req_ready;
	assign ACC_DONE = state.done;
	assign MEM_CTL = state.ctl;
	assign MEM_ADDR = state.addr;
	assign BYTE_SEL_MODE = state.byte_mode;
	assign PAGE_HIT = state.hit;
endmodule // static_mem_wait_slow_page
`default_nettype wire

/* smc_pkg.sv */
`default_nettype none
package static_mem_pkg;

	localparam int CS_BITS = 3;
	localparam int ADDR_BITS = 26;
	localparam int SETUP_BITS = 6;
	localparam int PULSE_BITS = 7;
	localparam int CYCLE_BITS = 9;
	localparam int CNT_BITS = 10;
	localparam int SYNC_STAGES = 2;

	// Wait mode encodings
	localparam logic [1:0] WAIT_OFF = 2'h0;
	localparam logic [1:0] WAIT_FROZEN = 2'h2;
	localparam logic [1:0] WAIT_READY = 2'h3;

	// Page size encodings
	localparam logic [1:0] PAGE_4 = 2'h0;
	localparam logic [1:0] PAGE_8 = 2'h1;
	localparam logic [1:0] PAGE_16 = 2'h2;
	localparam logic [1:0] PAGE_32 = 2'h3;

	// Data bus width encodings
	localparam logic [1:0] DBW_8 = 2'h0;
	localparam logic [1:0] DBW_16 = 2'h1;
	localparam logic [1:0] DBW_32 = 2'h2;

	// Slow clock fixed waveforms
	localparam logic [CNT_BITS-1:0] SLOW_STB_SETUP = 10'h001;
	localparam logic [CNT_BITS-1:0] SLOW_STB_PULSE = 10'h001;
	localparam logic [CNT_BITS-1:0] SLOW_CS_SETUP = 10'h000;
	localparam logic [CNT_BITS-1:0] SLOW_RD_CS_PULSE = 10'h002;
	localparam logic [CNT_BITS-1:0] SLOW_RD_CYCLE = 10'h002;
	localparam logic [CNT_BITS-1:0] SLOW_WR_CS_PULSE = 10'h003;
	localparam logic [CNT_BITS-1:0] SLOW_WR_CYCLE = 10'h003;

	// Reset values
	localparam logic SYNC_RESET_LEVEL = 1'b1;
	localparam logic [CNT_BITS-1:0] CNT_RESET = 10'h000;

	typedef struct packed {
		logic [SETUP_BITS-1:0] cs_rd_setup;
		logic [SETUP_BITS-1:0] rd_strobe_setup;
		logic [SETUP_BITS-1:0] cs_wr_setup;
		logic [SETUP_BITS-1:0] wr_strobe_setup;
		logic [PULSE_BITS-1:0] cs_rd_pulse;
		logic [PULSE_BITS-1:0] rd_strobe_pulse;
		logic [PULSE_BITS-1:0] cs_wr_pulse;
		logic [PULSE_BITS-1:0] wr_strobe_pulse;
		logic [CYCLE_BITS-1:0] rd_cycle_len;
		logic [CYCLE_BITS-1:0] wr_cycle_len;
		logic read_mode;
		logic write_mode;
		logic [1:0] wait_mode_sel;
		logic byte_access_type;
		logic [1:0] bus_width;
		logic page_mode_en;
		logic [1:0] page_size_sel;
	} cs_cfg_s;

	typedef struct packed {
		logic valid;
		logic write;
		logic [CS_BITS-1:0] cs;
		logic [ADDR_BITS-1:0] addr;
	} acc_req_s;

	typedef struct packed {
		logic chip_sel_n;
		logic read_strobe_n;
		logic write_strobe_n;
	} mem_ctl_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RUN = 3'b001,
		ST_PAGE = 3'b010,
		ST_RELOAD = 3'b011,
		ST_READY_HOLD = 3'b100
	} acc_state_e;

	function automatic logic [CNT_BITS-1:0] setup_len(input logic [SETUP_BITS-1:0] v);
		setup_len = v[5] ? (10'h080 + {5'h00, v[4:0]}) : {5'h00, v[4:0]};
	endfunction

	function automatic logic [CNT_BITS-1:0] pulse_len(input logic [PULSE_BITS-1:0] v);
		pulse_len = v[6] ? (10'h100 + {4'h0, v[5:0]}) : {4'h0, v[5:0]};
	endfunction

	function automatic logic [CNT_BITS-1:0] cycle_len(input logic [CYCLE_BITS-1:0] v);
		cycle_len = {v[8:7], 8'h00} + {3'h0, v[6:0]};
	endfunction

endpackage
`default_nettype wire

/* wait_sync.sv */
`default_nettype none
module wait_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw and synchronized wait
	input wire logic wait_n_in,
	output logic wait_n_sync
);
	import static_mem_pkg::*;

	typedef struct packed {
		logic [SYNC_STAGES-1:0] stage;
	} sync_s;

	sync_s state;
	sync_s next_state;

	always_comb begin
		next_state = state;
		next_state.stage = {state.stage[0], wait_n_in};
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state.stage <= {SYNC_STAGES{SYNC_RESET_LEVEL}}; // R23
		end else begin
			state <= next_state; // R9
		end
	end

	assign wait_n_sync = state.stage[SYNC_STAGES-1];
endmodule // wait_sync
`default_nettype wire

/* ext_wait_dev.sv */
`default_nettype none
module ext_wait_dev (
	// Clock
	input wire logic clk,
	// Controls from the controller and response timing
	input wire static_mem_pkg::mem_ctl_s ctl,
	input wire logic [7:0] lat,
	input wire logic [7:0] len,
	// Wait line, high while idle
	output logic wait_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import static_mem_pkg::*;
	logic stb;
	logic prev = 1'b0;
	logic [7:0] cnt = 8'h00;
	assign stb = !(ctl.read_strobe_n && ctl.write_strobe_n);
	// Answers a fixed time after the strobe falls, blind to any stall
	always @(posedge clk) begin
		prev <= stb;
		cnt <= (stb && !prev) ? 8'h01 : (cnt != 8'h00 && cnt != 8'hFF) ? cnt + 8'h01 : 8'h00;
		wait_n <= !(len != 8'h00 && cnt >= lat && cnt < lat + len);
	end
endmodule // ext_wait_dev
`default_nettype wire

/* static_mem_wait_slow_page_chk.sv */
`default_nettype none
module static_mem_wait_slow_page_chk (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// Request side
	input wire static_mem_pkg::acc_req_s REQ,
	input wire static_mem_pkg::cs_cfg_s CFG,
	input wire logic REQ_READY,
	input wire logic ACC_DONE,
	input wire logic SLOW_CLK_MODE,
	// Memory side
	input wire logic EXT_WAIT_N,
	input wire static_mem_pkg::mem_ctl_s MEM_CTL,
	input wire logic [static_mem_pkg::ADDR_BITS-1:0] MEM_ADDR,
	input wire logic BYTE_SEL_MODE,
	input wire logic PAGE_HIT
);
	timeunit 1ns;
	timeprecision 1ns;
	import static_mem_pkg::*;
	logic [8:0] rd_low, wr_low, cs_low;
	logic slow_acc, wr_acc;
	// Low-time counters and the mode of the access last taken
	always_ff @(posedge CORE_CLK) begin
		rd_low <= MEM_CTL.read_strobe_n ? 9'h000 : rd_low + 9'h001;
		wr_low <= MEM_CTL.write_strobe_n ? 9'h000 : wr_low + 9'h001;
		cs_low <= MEM_CTL.chip_sel_n ? 9'h000 : cs_low + 9'h001;
		if (REQ_READY && REQ.valid) begin
			slow_acc <= SLOW_CLK_MODE;
			wr_acc <= REQ.write;
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RSTN);
	sequence frozen_wait_s;
		CFG.wait_mode_sel == WAIT_FROZEN && !EXT_WAIT_N && !MEM_CTL.write_strobe_n;
	endsequence
	sequence idle_after_s;
		MEM_CTL == 3'h7 ##1 !ACC_DONE;
	endsequence
	a_off_pulse: assert property ($rose(MEM_CTL.read_strobe_n) && !slow_acc
		&& CFG.wait_mode_sel == WAIT_OFF && !CFG.page_mode_en
		|-> rd_low == {CFG.rd_strobe_pulse[6], 2'b00, CFG.rd_strobe_pulse[5:0]})
		else $error("read strobe length differs from pulse");
	a_slow_strobe: assert property (slow_acc
		&& ($rose(MEM_CTL.read_strobe_n) || $rose(MEM_CTL.write_strobe_n))
		|-> rd_low + wr_low == 9'h001) else $error("slow strobe not one cycle");
	a_slow_cs: assert property (slow_acc && $rose(MEM_CTL.chip_sel_n)
		|-> cs_low == (wr_acc ? 9'h003 : 9'h002)) else $error("slow chip select length");
	a_frozen_hold: assert property (frozen_wait_s [*5] |-> $stable(MEM_CTL))
		else $error("controls moved while frozen");
	a_ready_stall: assert property (
		CFG.wait_mode_sel == WAIT_READY && $rose(MEM_CTL.write_strobe_n)
		|-> $past(EXT_WAIT_N, 1) || $past(EXT_WAIT_N, 2) || $past(EXT_WAIT_N, 3))
		else $error("ready stall released under wait");
	a_page_edges: assert property (CFG.page_mode_en && !slow_acc && !wr_acc
		|-> $fell(MEM_CTL.read_strobe_n) == $fell(MEM_CTL.chip_sel_n)
		&& $rose(MEM_CTL.read_strobe_n) == $rose(MEM_CTL.chip_sel_n))
		else $error("page strobe and select differ");
	a_page_len: assert property (CFG.page_mode_en && !slow_acc && !wr_acc
		&& $rose(MEM_CTL.read_strobe_n) |-> rd_low == (PAGE_HIT
		? {CFG.rd_strobe_pulse[6], 2'b00, CFG.rd_strobe_pulse[5:0]}
		: {CFG.cs_rd_pulse[6], 2'b00, CFG.cs_rd_pulse[5:0]}))
		else $error("page access length wrong");
	a_byte_sel: assert property (!MEM_CTL.chip_sel_n
		|-> BYTE_SEL_MODE == CFG.byte_access_type) else $error("byte access type lost");
	a_page_offset: assert property (PAGE_HIT && CFG.bus_width == DBW_16
		|-> !MEM_ADDR[0]) else $error("in-page offset bit kept");
	a_done_idle: assert property (ACC_DONE |-> idle_after_s)
		else $error("done without idle controls");
	a_reset_idle: assert property ($rose(RSTN)
		|-> MEM_CTL == 3'h7 && !ACC_DONE && !PAGE_HIT)
		else $error("outputs not idle after reset");
endmodule // static_mem_wait_slow_page_chk
bind static_mem_wait_slow_page static_mem_wait_slow_page_chk i_chk (.CORE_CLK(CORE_CLK),
	.RSTN(RSTN), .REQ(REQ), .CFG(CFG), .REQ_READY(REQ_READY), .ACC_DONE(ACC_DONE),
	.SLOW_CLK_MODE(SLOW_CLK_MODE), .EXT_WAIT_N(EXT_WAIT_N), .MEM_CTL(MEM_CTL),
	.MEM_ADDR(MEM_ADDR), .BYTE_SEL_MODE(BYTE_SEL_MODE), .PAGE_HIT(PAGE_HIT));
`default_nettype wire

/* static_mem_wait_slow_page_test.sv */
`default_nettype none
module static_mem_wait_slow_page_test;
	timeunit 1ns;
	timeprecision 1ns;
	import static_mem_pkg::*;
	logic clk, rstn, slow, rdy, done, hit_o, wn, hit, bsel;
	logic [25:0] addr_o;
	logic [7:0] wlat, wlen;
	acc_req_s req;
	cs_cfg_s cfg;
	mem_ctl_s ctl;
	int fail_count, tests_run, cs_n, st_n;
	always #50 clk = ~clk;
	static_mem_wait_slow_page i_dut (.CORE_CLK(clk), .RSTN(rstn), .REQ(req), .CFG(cfg),
		.REQ_READY(rdy), .ACC_DONE(done), .SLOW_CLK_MODE(slow), .EXT_WAIT_N(wn),
		.MEM_CTL(ctl), .MEM_ADDR(addr_o), .BYTE_SEL_MODE(bsel), .PAGE_HIT(hit_o));
	ext_wait_dev i_dev (.clk(clk), .ctl(ctl), .lat(wlat), .len(wlen), .wait_n(wn));
	////////////////////////////////////////
	task automatic give_verdict();
		$display("Comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("[ERR] %s expected %0d seen %0d", n, e, s);
			fail_count++;
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic s);
		tests_run++;
		if (s !== e) begin
			$display("[ERR] %s expected %b seen %b", n, e, s);
			fail_count++;
		end
	endtask
	// One access; counts low cycles of select and strobes until done
	task automatic run(input acc_req_s r, input logic drop);
		int i;
		@(posedge clk) req <= r;
		@(negedge clk);
		for (i = 0; i < 50 && rdy !== 1'b1; i++)
			@(negedge clk);
		@(posedge clk) begin
			req.valid <= 1'b0;
			if (drop)
				slow <= 1'b0;
		end
		cs_n = 0;
		st_n = 0;
		for (i = (i == 50) ? 300 : 0; i < 300; i++) begin
			@(negedge clk);
			if (done === 1'b1)
				break;
			cs_n += int'(ctl.chip_sel_n === 1'b0);
			st_n += int'(ctl.read_strobe_n === 1'b0 || ctl.write_strobe_n === 1'b0);
			hit = hit_o;
		end
		if (i == 300) begin
			fail_count++;
			give_verdict();
		end
	endtask
	////////////////////////////////////////
	task automatic t_reset();
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk_bit("controls idle", 1'b1, &ctl);
		chk_bit("page hit idle", 1'b0, hit_o);
		$display("t_reset done");
	endtask
	task automatic t_wait();
		logic [1:0] m[6] = '{WAIT_OFF, WAIT_FROZEN, WAIT_FROZEN, WAIT_READY, WAIT_READY, WAIT_READY};
		logic [7:0] lt[6] = '{8'h01, 8'h01, 8'h0C, 8'h01, 8'h0C, 8'h01};
		logic [7:0] ln[6] = '{8'h04, 8'h06, 8'h03, 8'h03, 8'h03, 8'h0E};
		int ex[6] = '{10, 16, 10, 10, 10, 19};
		int i;
		for (i = 0; i < 6; i++) begin
			@(posedge clk) begin
				cfg.wait_mode_sel <= m[i];
				wlat <= lt[i];
				wlen <= ln[i];
			end
			run({1'b1, i != 0, 3'h1, 26'h0000040}, 1'b0);
			// Ready stall holds the strobe until the synchronised release
			chk("wait strobe", ex[i], st_n);
		end
		$display("t_wait done");
	endtask
	task automatic t_slow();
		@(posedge clk) begin
			slow <= 1'b1;
			cfg.wait_mode_sel <= WAIT_OFF;
		end
		run({1'b1, 1'b0, 3'h2, 26'h0000080}, 1'b0);
		chk("slow rd select", 2, cs_n);
		chk("slow rd strobe", 1, st_n);
		run({1'b1, 1'b1, 3'h2, 26'h0000080}, 1'b0);
		chk("slow wr select", 3, cs_n);
		chk("slow wr strobe", 1, st_n);
		run({1'b1, 1'b0, 3'h2, 26'h0000080}, 1'b1);
		chk("exit select", 2, cs_n);
		run({1'b1, 1'b0, 3'h2, 26'h0000080}, 1'b0);
		chk("normal strobe", 10, st_n);
		$display("t_slow done");
	endtask
	task automatic t_page();
		logic [30:0] q[8] = '{31'h44000100, 31'h44000106, 31'h44000103, 31'h48000104,
			31'h44000105, 31'h44000108, 31'h6400010A, 31'h4400010C};
		int ex[8] = '{9, 3, 3, 9, 9, 9, 10, 9};
		logic hx[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		int i;
		@(posedge clk) begin
			cfg.page_mode_en <= 1'b1;
			cfg.page_size_sel <= PAGE_8;
			cfg.cs_rd_pulse <= 7'h09;
			cfg.rd_strobe_pulse <= 7'h03;
			cfg.byte_access_type <= 1'b0;
		end
		for (i = 0; i < 8; i++) begin
			run(q[i], 1'b0);
			chk("page strobe", ex[i], st_n);
			chk_bit("page hit", hx[i], hit);
			chk("page addr", hx[i] ? {6'h00, q[i][25:1], 1'b0} : {6'h00, q[i][25:0]},
				{6'h00, addr_o});
			chk_bit("byte mode", 1'b0, bsel);
		end
		$display("t_page done");
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		slow = 1'b0;
		wlat = 8'h01;
		wlen = 8'h00;
		fail_count = 0;
		tests_run = 0;
		req = '0;
		cfg = '0;
		cfg.rd_strobe_setup = 6'h01;
		cfg.wr_strobe_setup = 6'h01;
		cfg.rd_strobe_pulse = 7'h0A;
		cfg.wr_strobe_pulse = 7'h0A;
		cfg.cs_rd_pulse = 7'h0C;
		cfg.cs_wr_pulse = 7'h0C;
		cfg.rd_cycle_len = 9'h014;
		cfg.wr_cycle_len = 9'h014;
		cfg.read_mode = 1'b1;
		cfg.write_mode = 1'b1;
		cfg.bus_width = DBW_16;
		cfg.byte_access_type = 1'b1;
		t_reset();
		t_wait();
		t_slow();
		t_page();
		give_verdict();
	end
endmodule // static_mem_wait_slow_page_test
`default_nettype wire
